// >>> rtl/apcp_pkg.sv
// Constants and carrier types for the asynchronous peripheral configuration port
// Functional notes
// - Byte taken at trailing edge of write condition
// - Busy goes low once byte is buffered
// - Surplus data shifted out on daisy output
// - Busy released when buffer hands byte over
// - Ready pin undriven before init goes high
// - Busy up to two periods if shifter empty
// - Busy up to nine periods if shifter full
// - Final byte shifts seven bits, holds bit six
// - Status read drives status onto data bus
// - Status bit seven ready, others high
// - Start-up completes within one final byte
// - Missing final byte leaves start-up incomplete
// - Port selected by mode pattern 101
// - Power-on reset lasts ten to thirty-three ms
package apcp_pkg;
    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam logic [2:0]  MODE_ASYNC_PERIPH = 3'h5;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          POR_MIN_MS        = 10;
    localparam int          POR_CYCLES        = POR_MIN_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          CONFIG_CLOCK_DIV          = 8;      // Config clock = 8 system cycles
    localparam logic [3:0]  BITS_FULL         = 4'h8;
    localparam logic [3:0]  BITS_LAST         = 4'h7;
    localparam logic [7:0]  STATUS_FILL       = 8'h7F;
    localparam logic [1:0]  BUF_DEPTH         = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } apcp_word_type;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } apcp_bus_type;
endpackage

// >>> rtl/apcp_port.sv
// Asynchronous peripheral configuration port: write buffer, serialiser, status read
`timescale 1ns/100ps
module apcp_port #(
    parameter int POR_CYC = apcp_pkg::POR_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_config_mode_pins,
    input  wire logic       i_init,
    input  wire logic       i_write_strobe_n,
    input  wire logic       i_read_strobe_n,
    input  wire logic       i_chip_select_low_active,
    input  wire logic       i_chip_select_high_active,
    input  wire logic [7:0] i_data,
    input  wire logic       i_last_byte,
    input  wire logic       i_dout_ready,
    output logic      [7:0] o_data,
    output logic      [7:0] o_data_oe,
    output logic            o_rdy_busy,
    output logic            o_rdy_busy_oe,
    output logic            o_config_clock,
    output logic            o_dout,
    output logic            o_dout_valid,
    output logic            o_startup_done
);
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic sel_mode;
    logic wr_cond;
    logic rd_cond;
    assign sel_mode = (i_config_mode_pins == apcp_pkg::MODE_ASYNC_PERIPH);
    assign wr_cond  = sel_mode & ~i_write_strobe_n & ~i_chip_select_low_active
                    & i_read_strobe_n & i_chip_select_high_active;
    assign rd_cond  = sel_mode & ~i_read_strobe_n & ~i_chip_select_low_active
                    & i_write_strobe_n & i_chip_select_high_active;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                  wr_d_r, wr_d_nxt;
    logic [31:0]           por_r, por_nxt;
    logic                  por_done_r, por_done_nxt;
    apcp_pkg::apcp_word_type buf_r [2];
    apcp_pkg::apcp_word_type buf_nxt [2];
    logic [1:0]            cnt_r, cnt_nxt;
    logic [7:0]            sh_r, sh_nxt;
    logic [3:0]            left_r, left_nxt;
    logic                  sh_last_r, sh_last_nxt;
    logic [2:0]            div_r, div_nxt;
    logic                  config_clock_r, config_clock_nxt;
    logic                  dout_r, dout_nxt;
    logic                  dv_r, dv_nxt;
    logic                  rdy_r, rdy_nxt;
    logic                  rdy_oe_r, rdy_oe_nxt;
    logic                  done_r, done_nxt;
    logic                  config_clock_pin_r, config_clock_pin_nxt;
    logic [7:0]            wdat_r, wdat_nxt;
    logic                  wlast_r, wlast_nxt;
    apcp_pkg::apcp_bus_type bus_r, bus_nxt;
    logic                  tick;
    logic                  take;
    logic                  load;

    // Write is taken when the condition falls, never while held
    assign take = wr_d_r & ~wr_cond & sel_mode & por_done_r & i_init;
    assign tick = (div_r == 3'(apcp_pkg::CONFIG_CLOCK_DIV / 2 - 1));
    // Serialiser reloads on a falling config clock edge only
    assign load = tick & config_clock_r & (left_r == 4'h0) & (cnt_r != 2'h0);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        wr_d_nxt     = wr_cond;
        por_nxt      = por_r;
        por_done_nxt = por_done_r;
        buf_nxt      = buf_r;
        cnt_nxt      = cnt_r;
        sh_nxt       = sh_r;
        left_nxt     = left_r;
        sh_last_nxt  = sh_last_r;
        div_nxt      = tick ? 3'h0 : div_r + 3'h1;
        config_clock_nxt     = tick ? ~config_clock_r : config_clock_r;
        dout_nxt     = dout_r;
        dv_nxt       = dv_r;
        done_nxt     = done_r;
        // Hold the byte while the write condition stands; the host may drop it at release
        wdat_nxt     = wr_cond ? i_data : wdat_r;
        wlast_nxt    = wr_cond ? i_last_byte : wlast_r;
        // Power-on wait before any write is accepted; status reads are answered during it
        if (!por_done_r) begin
            por_nxt = por_r + 32'h0000_0001;
            if (por_r >= 32'(POR_CYC - 1)) begin
                por_done_nxt = 1'b1;
            end
        end
        // Two-entry buffer, entry 0 is the head
        if (load) begin
            sh_nxt      = buf_r[0].data;
            sh_last_nxt = buf_r[0].last;
            left_nxt    = buf_r[0].last ? apcp_pkg::BITS_LAST : apcp_pkg::BITS_FULL;
            buf_nxt[0]  = buf_r[1];
            cnt_nxt     = cnt_r - 2'h1;
        end
        if (take && cnt_nxt != apcp_pkg::BUF_DEPTH) begin
            buf_nxt[cnt_nxt[0]].data = wdat_r;
            buf_nxt[cnt_nxt[0]].last = wlast_r;
            cnt_nxt                  = cnt_nxt + 2'h1;
        end
        // Valid drops on a config clock fall that shifts nothing, so a pause repeats no bit
        if (tick && config_clock_r) begin
            dv_nxt = 1'b0;
        end
        // Shift on falling config clock edge, bit 0 first, stall while receiver not ready
        if (tick && config_clock_r && left_r != 4'h0 && !load && i_dout_ready) begin
            dout_nxt = sh_r[0];
            dv_nxt   = 1'b1;
            sh_nxt   = {1'b0, sh_r[7:1]};
            left_nxt = left_r - 4'h1;
        end
        // Final byte stops on bit six; start-up ends at the rise that clocks it
        if (tick && !config_clock_r && left_r == 4'h0 && sh_last_r) begin
            done_nxt = 1'b1;
        end
        // Ready once the buffer is empty; busy right after a take
        rdy_nxt    = (cnt_nxt == 2'h0) & ~take;
        rdy_oe_nxt = i_init & por_done_r;
        bus_nxt.data = rd_cond ? (apcp_pkg::STATUS_FILL | {rdy_r, 7'h00}) : 8'h00;
        bus_nxt.oe   = rd_cond ? 8'hFF : 8'h00;
        // Pin copy of the config clock, parked high once start-up is done
        config_clock_pin_nxt = config_clock_nxt | done_nxt;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_d_r     <= 1'b0;
            por_r      <= 32'h0000_0000;
            por_done_r <= 1'b0;
            buf_r[0]   <= '0;
            buf_r[1]   <= '0;
            cnt_r      <= 2'h0;
            sh_r       <= 8'h00;
            left_r     <= 4'h0;
            sh_last_r  <= 1'b0;
            div_r      <= 3'h0;
            config_clock_r     <= 1'b0;
            dout_r     <= 1'b0;
            dv_r       <= 1'b0;
            rdy_r      <= 1'b1;
            rdy_oe_r   <= 1'b0;
            done_r     <= 1'b0;
            config_clock_pin_r <= 1'b0;
            wdat_r     <= 8'h00;
            wlast_r    <= 1'b0;
            bus_r      <= '0;
        end else begin
            wr_d_r     <= wr_d_nxt;
            por_r      <= por_nxt;
            por_done_r <= por_done_nxt;
            buf_r      <= buf_nxt;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            left_r     <= left_nxt;
            sh_last_r  <= sh_last_nxt;
            div_r      <= div_nxt;
            config_clock_r     <= config_clock_nxt;
            dout_r     <= dout_nxt;
            dv_r       <= dv_nxt;
            rdy_r      <= rdy_nxt;
            rdy_oe_r   <= rdy_oe_nxt;
            done_r     <= done_nxt;
            config_clock_pin_r <= config_clock_pin_nxt;
            wdat_r     <= wdat_nxt;
            wlast_r    <= wlast_nxt;
            bus_r      <= bus_nxt;
        end
    end

    // Config clock parks high after the final byte
    assign o_config_clock = config_clock_pin_r;
    assign o_dout         = dout_r;
    assign o_dout_valid   = dv_r;
    assign o_rdy_busy     = rdy_r;
    assign o_rdy_busy_oe  = rdy_oe_r;
    assign o_startup_done = done_r;
    assign o_data         = bus_r.data;
    assign o_data_oe      = bus_r.oe;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_busy_after_take;
        @(posedge i_mclk) disable iff (!i_rst_n) take |=> !o_rdy_busy;
    endproperty
    a_busy_after_take: assert property (p_busy_after_take) else $error("no busy after write");

    property p_ready_free;
        @(posedge i_mclk) disable iff (!i_rst_n) (cnt_r == 2'h0 && !take) |=> o_rdy_busy;
    endproperty
    a_ready_free: assert property (p_ready_free) else $error("ready not restored");

    property p_no_drive_pre_init;
        @(posedge i_mclk) disable iff (!i_rst_n) !i_init |=> !o_rdy_busy_oe;
    endproperty
    a_no_drive_pre_init: assert property (p_no_drive_pre_init) else $error("driven before init");

    property p_busy_short;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (take && cnt_r == 2'h0 && left_r == 4'h0) |-> ##[1:16] o_rdy_busy;
    endproperty
    a_busy_short: assert property (p_busy_short) else $error("busy too long, empty shifter");

    property p_busy_long;
        // A stalled receiver holds the shifter, so no bound applies then
        @(posedge i_mclk) disable iff (!i_rst_n || !i_dout_ready)
            (take && cnt_r == 2'h0) |-> ##[1:72] o_rdy_busy;
    endproperty
    a_busy_long: assert property (p_busy_long) else $error("busy beyond nine periods");

    property p_status;
        @(posedge i_mclk) disable iff (!i_rst_n)
            rd_cond |=> (o_data[6:0] == 7'h7F && o_data[7] == $past(rdy_r) && o_data_oe == 8'hFF);
    endproperty
    a_status: assert property (p_status) else $error("bad status value");

    property p_bus_idle;
        @(posedge i_mclk) disable iff (!i_rst_n) !rd_cond |=> o_data_oe == 8'h00;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("bus driven outside read");

    property p_park_high;
        @(posedge i_mclk) disable iff (!i_rst_n) done_r |-> o_config_clock && $stable(o_dout);
    endproperty
    a_park_high: assert property (p_park_high) else $error("clock not parked");

    property p_mode_gate;
        @(posedge i_mclk) disable iff (!i_rst_n) !sel_mode |-> !take;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("write taken in wrong mode");

    c_take:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) take);
    c_full:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) cnt_r == 2'h2);
    c_read:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) rd_cond && !rdy_r);
    c_done:   cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(done_r));
endmodule

// >>> bench/apcp_host.sv
// Host bus model that writes configuration bytes and reads status
`timescale 1ns/100ps
module apcp_host (
    input  wire logic       i_mclk,
    input  wire logic       i_rdy,
    input  wire logic [7:0] i_bus,
    output logic            o_ws_n,
    output logic            o_rs_n,
    output logic            o_cs0_n,
    output logic            o_cs1,
    output logic      [7:0] o_data
);
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // Bus idles deselected
    initial begin
        o_ws_n  = 1'b1;
        o_rs_n  = 1'b1;
        o_cs0_n = 1'b1;
        o_cs1   = 1'b0;
        o_data  = 8'h00;
    end

    // Without handshake the strobe is short; callers space writes instead
    task automatic write_byte(input logic [7:0] d, input bit hs);
        int run;
        int n;
        @(posedge i_mclk);
        o_ws_n  <= 1'b0;
        o_cs0_n <= 1'b0;
        o_cs1   <= 1'b1;
        o_data  <= d;
        run = 0;
        n = 0;
        while (hs && run < 8 && n < 300) begin
            @(posedge i_mclk);
            run = i_rdy ? run + 1 : 0;
            n++;
        end
        @(posedge i_mclk);
        o_ws_n  <= 1'b1;
        o_cs0_n <= 1'b1;
        o_cs1   <= 1'b0;
        o_data  <= ~d; // Released lines must not keep the byte
    endtask

    // Status read; undriven bus bits would read low here
    task automatic read_status(output logic [7:0] v);
        @(posedge i_mclk);
        o_rs_n  <= 1'b0;
        o_cs0_n <= 1'b0;
        o_cs1   <= 1'b1;
        o_data  <= 8'h00;
        repeat (3) @(posedge i_mclk);
        v = i_bus;
        o_rs_n  <= 1'b1;
        o_cs0_n <= 1'b1;
        o_cs1   <= 1'b0;
    endtask
endmodule

// >>> bench/apcp_port_test.sv
// Self-checking bench for the configuration port
`timescale 1ns/100ps
module apcp_port_test;
    logic       i_mclk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic [2:0] mode = 3'h5;
    logic       init = 1'b0;
    logic       last = 1'b0;
    logic       dready = 1'b1;
    logic       ws_n, rs_n, cs0_n, cs1, rb, rb_oe, config_clock, dout, dval, done, cc_q;
    logic [7:0] hdata, o_data, o_oe, v;
    int         mismatches = 0;
    int         checked = 0;
    int         n;
    logic       exp_q[$];
    logic       got_q[$];
    wire        rdy_w = rb_oe ? rb : 1'b1; // Pull-up while undriven
    wire  [7:0] bus_w = (o_data & o_oe) | (hdata & ~o_oe);

    apcp_port #(.POR_CYC(20)) apcp_port_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_config_mode_pins(mode), .i_init(init), .i_write_strobe_n(ws_n),
        .i_read_strobe_n(rs_n), .i_chip_select_low_active(cs0_n),
        .i_chip_select_high_active(cs1), .i_data(hdata), .i_last_byte(last),
        .i_dout_ready(dready), .o_data(o_data), .o_data_oe(o_oe), .o_rdy_busy(rb),
        .o_rdy_busy_oe(rb_oe), .o_config_clock(config_clock), .o_dout(dout),
        .o_dout_valid(dval), .o_startup_done(done));
    apcp_host apcp_host_inst (.i_mclk(i_mclk), .i_rdy(rdy_w), .i_bus(bus_w),
        .o_ws_n(ws_n), .o_rs_n(rs_n), .o_cs0_n(cs0_n), .o_cs1(cs1), .o_data(hdata));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Clock and watchdog; the tests need well under 5000 cycles
    initial forever #5 i_mclk = ~i_mclk;
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
    // Serial bits are taken on rising config clock, clear of their change
    always @(posedge i_mclk) begin
        cc_q <= config_clock;
        if (config_clock === 1'b1 && cc_q === 1'b0 && dval === 1'b1) got_q.push_back(dout);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] d, input logic lst, input bit hs);
        @(posedge i_mclk);
        last <= lst;
        for (int i = 0; i <= (lst ? 6 : 7); i++) exp_q.push_back(d[i]);
        apcp_host_inst.write_byte(d, hs);
    endtask
    // Counts busy cycles after a write, bounded
    task automatic busy_span(output int k);
        k = 0;
        repeat (3) if (rdy_w) @(posedge i_mclk);
        while (!rdy_w && k < 300) begin
            @(posedge i_mclk);
            k++;
        end
    endtask
    task automatic drain;
        int k;
        k = 0;
        while (got_q.size() < exp_q.size() && k < 900) begin
            @(posedge i_mclk);
            k++;
        end
        chk(8'(got_q.size()), 8'(exp_q.size()));
        foreach (exp_q[i]) if (i < got_q.size()) chk(8'(got_q[i]), 8'(exp_q[i]));
        exp_q.delete();
        got_q.delete();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        repeat (10) @(posedge i_mclk);
        chk({6'h0, rb_oe, rb}, 8'h01);
        i_rst_n <= 1'b1;
        repeat (30) @(posedge i_mclk);
        chk({6'h0, rb_oe, rdy_w}, 8'h01);
        repeat (400) @(posedge i_mclk);
    endtask
    task automatic t_mode;
        mode <= 3'h3;
        init <= 1'b1;
        wr(8'hF0, 1'b0, 1'b0);
        busy_span(n);
        chk(8'(n), 8'h00);
        repeat (100) @(posedge i_mclk);
        chk(8'(got_q.size()), 8'h00);
        exp_q.delete();
        mode <= 3'h5;
    endtask
    task automatic t_status;
        apcp_host_inst.read_status(v);
        chk(v, 8'hFF);
        repeat (2) @(posedge i_mclk);
        chk(o_oe, 8'h00);
    endtask
    task automatic t_single;
        wr(8'hA5, 1'b0, 1'b1);
        busy_span(n);
        chk(8'(n > 0 && n <= 16), 8'h01);
        drain;
    endtask
    task automatic t_busy_read;
        wr(8'h3C, 1'b0, 1'b1);
        busy_span(n);
        wr(8'h96, 1'b0, 1'b1);
        apcp_host_inst.read_status(v);
        chk(v, 8'h7F);
        busy_span(n);
        chk(8'(n <= 72), 8'h01);
        drain;
    endtask
    task automatic t_stall;
        dready <= 1'b0;
        wr(8'h81, 1'b0, 1'b0);
        repeat (90) @(posedge i_mclk);
        wr(8'h5A, 1'b0, 1'b0);
        repeat (150) @(posedge i_mclk);
        chk(8'(rdy_w), 8'h00);
        dready <= 1'b1;
        drain;
    endtask
    task automatic t_final;
        chk(8'(done), 8'h00);
        wr(8'h40, 1'b1, 1'b1);
        drain;
        repeat (40) @(posedge i_mclk);
        chk({6'h0, done, config_clock}, 8'h03);
        repeat (16) @(posedge i_mclk);
        chk({6'h0, config_clock, dout}, 8'h03);
    endtask

    // Main sequence
    initial begin
        t_reset;
        t_mode;
        t_status;
        t_single;
        t_busy_read;
        t_stall;
        t_final;
        final_report;
    end
endmodule
